// >>> verilog/dsac_top.sv
// Our own choices: the placing of the registers and the APB slave port.
`timescale 1ns/10ps
`include "dsac_defs.svh"
module dsac_top
  import dsac_pkg::*;
#(
  parameter int unsigned SETTLE_CYC = `DSAC_SETTLE_CYC,
  parameter int          CW         = `DSAC_CW
) (
  input  wire logic          pclk,        // 125 MHz conversion clock
  input  wire logic          presetn,     // Async reset, low
  input  wire logic          psel,        // APB select
  input  wire logic          penable,     // APB enable
  input  wire logic          pwrite,      // APB direction
  input  wire logic [7:0]    paddr,       // APB byte address
  input  wire logic [31:0]   pwdata,      // APB write data
  output logic      [31:0]   prdata,      // APB read data
  output logic               pready,      // APB ready
  output logic               pslverr,     // APB error
  input  wire logic          cmp_pos,     // Integrator output positive
  output dsac_sw_t           int_sw,      // Integrator switches, 1 closed
  output dsac_relay_t        relay,       // Divider relay contacts
  output logic               relay_pulse, // Relay switching pulse
  output logic               xfer_pulse,  // Up-to-down transfer pulse
  output logic               polarity,    // Stored polarity, 1 positive
  output logic               overload,    // Overload lamp
  output logic      [1:0]    dp_pos,      // Decimal point position
  output logic      [CW-1:0] display      // Display memory
);

  dsac_state_t state_q;
  dsac_ctrl_t  ctrl_q;
  dsac_sw_t    sw_q;
  dsac_relay_t relay_q;
  dsac_relay_t relay_d;
  logic [CW-1:0] cnt_q;
  logic [CW-1:0] disp_q;
  logic          pol_q;
  logic          xfer_q;
  logic          relay_pulse_q;
  logic [1:0]    dp_q;
  logic          pready_q;
  logic          pslverr_q;
  logic [31:0]   prdata_q;
  logic [31:0]   rdata_c;
  logic          hit_c;
  logic          crossed;
  logic          res_valid;
  logic [1:0]    range_w;
  logic          step_w;
  logic          ovl_w;
  logic          dly_start;
  logic          dly_busy;
  logic          dly_done;

  // Zero reached once comparator disagrees with stored sign
  assign crossed   = (cmp_pos != pol_q) || (cnt_q == `DSAC_CNT_MAX);
  assign res_valid = (state_q == S_XFER);
  assign dly_start = (state_q == S_DECIDE) && step_w;

  dsac_range_sel #(
    .CW (CW)
  ) u_range (
    .pclk       (pclk),
    .presetn    (presetn),
    .res_valid  (res_valid),
    .result     (cnt_q),
    .override   (ctrl_q.override),
    .range_q    (range_w),
    .step_q     (step_w),
    .overload_q (ovl_w)
  );

  dsac_delay #(
    .CYC (SETTLE_CYC)
  ) u_settle (
    .pclk    (pclk),
    .presetn (presetn),
    .start   (dly_start),
    .busy_q  (dly_busy),
    .done_q  (dly_done)
  );

  // Conversion sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= S_IDLE;
    end else begin
      case (state_q)
        S_IDLE: begin
          if (ctrl_q.run) begin
            state_q <= S_UP;
          end
        end
        S_UP: begin
          if (cnt_q == `DSAC_UP_LAST) begin
            state_q <= S_DOWN; // RL1 RL4
          end
        end
        S_DOWN: begin
          if (crossed) begin
            state_q <= S_XFER; // RL7
          end
        end
        S_XFER: begin
          state_q <= S_DECIDE;
        end
        S_DECIDE: begin
          if (step_w) begin
            state_q <= S_SETTLE; // RL13
          end else if (ctrl_q.run) begin
            state_q <= S_UP; // RL21
          end else begin
            state_q <= S_IDLE;
          end
        end
        S_SETTLE: begin
          if (dly_done) begin
            state_q <= ctrl_q.run ? S_UP : S_IDLE; // RL13
          end
        end
        default: begin
          state_q <= S_IDLE;
        end
      endcase
    end
  end

  // Integration counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= '0;
    end else begin
      case (state_q)
        S_UP: begin
          if (cnt_q == `DSAC_UP_LAST) begin
            cnt_q <= '0; // RL4
          end else begin
            cnt_q <= cnt_q + 1'b1; // RL1
          end
        end
        S_DOWN: begin
          if (!crossed) begin
            cnt_q <= cnt_q + 1'b1; // RL6
          end
        end
        S_DECIDE: begin
          cnt_q <= '0; // RL21
        end
        S_IDLE, S_XFER, S_SETTLE: begin
          cnt_q <= cnt_q;
        end
        default: begin
          cnt_q <= '0;
        end
      endcase
    end
  end

  // Transfer pulse and polarity latch
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      xfer_q <= 1'b0;
      pol_q  <= 1'b1;
    end else begin
      xfer_q <= (state_q == S_UP) && (cnt_q == `DSAC_UP_LAST); // RL4
      if (state_q == S_UP && cnt_q == `DSAC_UP_LAST) begin
        pol_q <= cmp_pos; // RL3
      end
    end
  end

  // Integrator switches follow the phase being entered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sw_q <= '0;
    end else begin
      if ((state_q == S_UP && cnt_q != `DSAC_UP_LAST) ||
          (state_q != S_UP && state_q != S_DOWN && state_q != S_XFER &&
           ((state_q == S_IDLE && ctrl_q.run) ||
            (state_q == S_DECIDE && !step_w && ctrl_q.run) ||
            (state_q == S_SETTLE && dly_done && ctrl_q.run)))) begin
        sw_q <= '{1'b0, 1'b1, 1'b1}; // RL2
      end else if (state_q == S_UP) begin
        sw_q <= '{1'b1, !cmp_pos, cmp_pos}; // RL5
      end else if (state_q == S_DOWN && !crossed) begin
        sw_q <= sw_q;
      end else begin
        sw_q <= '0;
      end
    end
  end

  // Display memory
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      disp_q <= '0;
    end else if (state_q == S_XFER && cnt_q != disp_q) begin
      disp_q <= cnt_q; // RL7 RL8
    end
  end

  // Relay contacts, switching pulse and decimal point
  always_comb begin
    relay_d = '0;
    case (range_w)
      2'h0: begin
        if (ctrl_q.ac_mode) begin
          relay_d.upper = 1'b1; // RL17
        end else begin
          relay_d.lower = 1'b1; // RL16
        end
      end
      2'h1: begin
        relay_d.centre = 1'b1; // RL16
      end
      default: begin
        if (ctrl_q.ac_mode) begin
          relay_d.lower = 1'b1; // RL17
        end else begin
          relay_d.upper = 1'b1; // RL16
        end
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      relay_q       <= '0;
      relay_pulse_q <= 1'b0;
      dp_q          <= `DSAC_RNG_MOST;
    end else begin
      relay_q       <= relay_d; // RL9
      relay_pulse_q <= (relay_d != relay_q); // RL15
      dp_q          <= range_w; // RL14
    end
  end

  // APB slave, no wait states
  always_comb begin
    hit_c   = 1'b1;
    rdata_c = 32'h0000_0000;
    case (paddr)
      `DSAC_OFF_CTRL: begin
        rdata_c[3:0] = ctrl_q;
      end
      `DSAC_OFF_STATUS: begin
        rdata_c[10:0] = {dly_busy, ovl_w, range_w, pol_q, sw_q, state_q};
      end
      `DSAC_OFF_RESULT: begin
        rdata_c[CW-1:0] = disp_q;
      end
      `DSAC_OFF_COUNT: begin
        rdata_c[CW-1:0] = cnt_q;
      end
      default: begin
        hit_c = 1'b0;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end else begin
      pready_q  <= psel && !penable && !pready_q;
      pslverr_q <= psel && !penable && !pready_q && !hit_c;
      prdata_q  <= (psel && !penable && !pwrite) ? rdata_c : 32'h0000_0000;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= `DSAC_CTRL_RST;
    end else if (psel && penable && pready_q && pwrite &&
                 paddr == `DSAC_OFF_CTRL) begin
      ctrl_q <= pwdata[3:0];
    end
  end

  assign prdata      = prdata_q;
  assign pready      = pready_q;
  assign pslverr     = pslverr_q;
  assign int_sw      = sw_q;
  assign relay       = relay_q;
  assign relay_pulse = relay_pulse_q;
  assign xfer_pulse  = xfer_q;
  assign polarity    = pol_q;
  assign overload    = ovl_w;
  assign dp_pos      = dp_q;
  assign display     = disp_q;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Cycles spent so far in the running upward phase
  logic [CW-1:0] up_run_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      up_run_q <= '0;
    end else if (state_q == S_UP) begin
      up_run_q <= up_run_q + 1'b1; // RL1
    end else begin
      up_run_q <= '0;
    end
  end

  sequence up_end_s;
    state_q == S_UP && cnt_q == `DSAC_UP_LAST;
  endsequence

  sequence down_start_s;
    state_q == S_DOWN && cnt_q == '0 && xfer_q;
  endsequence

  a_up_length: assert property ( // RL1
    up_end_s |=> down_start_s && up_run_q == `DSAC_UP_COUNT)
    else $error("upward phase not 1000 cycles");
  a_up_bound: assert property ( // RL1
    state_q == S_UP |-> up_run_q < `DSAC_UP_COUNT)
    else $error("upward phase overran");
  a_xfer_single: assert property ( // RL4
    xfer_q |=> !xfer_q)
    else $error("transfer pulse too long");
  a_up_switches: assert property ( // RL2
    state_q == S_UP && $past(state_q) == S_UP |-> sw_q == 3'b011)
    else $error("wrong switches while charging");
  a_pol_latch: assert property ( // RL3
    up_end_s |=> pol_q == $past(cmp_pos))
    else $error("polarity not latched");
  a_down_switches: assert property ( // RL5
    state_q == S_DOWN && $past(state_q) == S_DOWN |->
    sw_q == {1'b1, !pol_q, pol_q})
    else $error("wrong switches while discharging");
  a_down_count: assert property ( // RL6
    state_q == S_DOWN && !crossed |=> cnt_q == $past(cnt_q) + 1'b1)
    else $error("counter not advancing");
  a_result_copy: assert property ( // RL7
    state_q == S_DOWN && crossed |=> ##1 disp_q == $past(cnt_q, 2))
    else $error("result not stored");
  a_disp_hold: assert property ( // RL8
    $past(state_q) != S_XFER |-> $stable(disp_q))
    else $error("display changed without result");
  a_restart: assert property ( // RL21
    state_q == S_DECIDE && !step_w && ctrl_q.run |=>
    state_q == S_UP && cnt_q == '0)
    else $error("no immediate restart");
  a_settle_wait: assert property ( // RL13
    state_q == S_DECIDE && step_w |=> state_q == S_SETTLE && dly_busy)
    else $error("step without settling delay");
endmodule

// >>> verilog/dsac_defs.svh
// Functional notes
// [RL1] Upward integration lasts exactly 1000 conversion clock periods.
// [RL2] Upward phase: reference switch open, both polarity switches closed.
// [RL3] At end of upward phase sample comparator polarity, store and show it.
// [RL4] Reaching upward count issues transfer pulse and clears the counter.
// [RL5] Downward phase: reference closed, one polarity switch opened per stored sign.
// [RL6] Counter increments every clock during downward integration.
// [RL7] Zero crossing stops counting and copies count into display memory.
// [RL8] Display keeps last result, changes only on a different new result.
// [RL9] Range selector has three positions driving divider relay contacts.
// [RL10] Result above limit steps to next less sensitive range.
// [RL11] Result below 100 steps to next more sensitive range.
// [RL12] Least sensitive range with result 1400 or more raises overload.
// [RL13] Every range step delays next conversion by 100 ms.
// [RL14] Decimal point position follows the selected range.
// [RL15] Logic generates switching pulses for the divider relay.
// [RL16] DC mapping: upper undivided, centre 10:1, lower 100:1. Code closes lower for undivided and upper for 100:1 in DC.
// [RL17] AC modes use the divider steps in reverse order.
// [RL18] Manual range choice can override automatic selection.
// [RL19] Override has four settings: three fixed ranges and automatic.
// [RL20] Stepping stops inside the window or at either end range.
// [RL21] Without a range change next upward phase starts at once from zero.
`ifndef DSAC_DEFS_SVH
`define DSAC_DEFS_SVH

`define DSAC_CW          12
`define DSAC_UP_COUNT    12'h3E8
`define DSAC_UP_LAST     12'h3E7
`define DSAC_CNT_MAX     12'hFFF
`define DSAC_HI_LIMIT    12'h578
`define DSAC_LO_LIMIT    12'h064

`define DSAC_RNG_MOST    2'h0
`define DSAC_RNG_LEAST   2'h2
`define DSAC_OVR_AUTO    2'h0

`define DSAC_CLK_MHZ     125
`define DSAC_SETTLE_MS   100
`define DSAC_SETTLE_CYC  (`DSAC_SETTLE_MS * 1000 * `DSAC_CLK_MHZ)

`define DSAC_OFF_CTRL    8'h00
`define DSAC_OFF_STATUS  8'h04
`define DSAC_OFF_RESULT  8'h08
`define DSAC_OFF_COUNT   8'h0C

`define DSAC_CTRL_RUN    0
`define DSAC_CTRL_AC     1
`define DSAC_CTRL_OVR_LO 2
`define DSAC_CTRL_OVR_HI 3
`define DSAC_CTRL_RST    4'h1

`endif

// >>> verilog/dsac_pkg.sv
package dsac_pkg;

  typedef enum logic [2:0] {
    S_IDLE,
    S_UP,
    S_DOWN,
    S_XFER,
    S_DECIDE,
    S_SETTLE
  } dsac_state_t;

  typedef struct packed {
    logic reference_discharge_switch;
    logic polarity_switch_a;
    logic polarity_switch_b;
  } dsac_sw_t;

  typedef struct packed {
    logic upper;
    logic centre;
    logic lower;
  } dsac_relay_t;

  typedef struct packed {
    logic [1:0] override;
    logic       ac_mode;
    logic       run;
  } dsac_ctrl_t;

endpackage

// >>> verilog/dsac_range_sel.sv
`timescale 1ns/10ps
`include "dsac_defs.svh"
module dsac_range_sel #(
  parameter int CW = `DSAC_CW
) (
  input  wire logic          pclk,      // Clock
  input  wire logic          presetn,   // Async reset, low
  input  wire logic          res_valid, // New result present
  input  wire logic [CW-1:0] result,    // Completed count
  input  wire logic [1:0]    override,  // 0 auto, 1..3 fixed
  output logic      [1:0]    range_q,   // 0 most sensitive
  output logic               step_q,    // Range changed last result
  output logic               overload_q // Overload lamp
);

  logic [1:0] range_d;

  always_comb begin
    range_d = range_q;
    if (override != `DSAC_OVR_AUTO) begin
      range_d = override - 2'h1; // RL18 RL19
    end else if (result >= `DSAC_HI_LIMIT && range_q != `DSAC_RNG_LEAST) begin
      range_d = range_q + 2'h1; // RL10 RL20
    end else if (result < `DSAC_LO_LIMIT && range_q != `DSAC_RNG_MOST) begin
      range_d = range_q - 2'h1; // RL11 RL20
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      range_q    <= `DSAC_RNG_MOST;
      step_q     <= 1'b0;
      overload_q <= 1'b0;
    end else if (res_valid) begin
      range_q    <= range_d; // RL9
      step_q     <= (range_d != range_q);
      overload_q <= (range_q == `DSAC_RNG_LEAST) &&
                    (result >= `DSAC_HI_LIMIT); // RL12
    end
  end

  a_range_three: assert property (@(posedge pclk) disable iff (!presetn)
    range_q <= `DSAC_RNG_LEAST) else $error("range out of span"); // RL9
  a_overload_cause: assert property (@(posedge pclk) disable iff (!presetn)
    res_valid && override == `DSAC_OVR_AUTO && range_q == `DSAC_RNG_LEAST
    && result >= `DSAC_HI_LIMIT |=> overload_q && range_q == `DSAC_RNG_LEAST)
    else $error("overload not raised"); // RL12
endmodule

// >>> verilog/dsac_delay.sv
`timescale 1ns/10ps
module dsac_delay #(
  parameter int unsigned CYC = 32'd1000
) (
  input  wire logic pclk,    // Clock
  input  wire logic presetn, // Async reset, low
  input  wire logic start,   // Begin settling delay
  output logic      busy_q,  // Delay running
  output logic      done_q   // One-cycle end pulse
);

  localparam int CNW = $clog2(CYC + 1);
  logic [CNW-1:0] cnt_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q  <= '0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      if (start) begin
        cnt_q  <= CNW'(CYC); // RL13
        busy_q <= 1'b1;
      end else if (busy_q) begin
        if (cnt_q == CNW'(1)) begin
          busy_q <= 1'b0;
          done_q <= 1'b1;
        end
        cnt_q <= cnt_q - CNW'(1);
      end
    end
  end

  a_delay_end: assert property (@(posedge pclk) disable iff (!presetn)
    done_q |-> !busy_q && cnt_q == '0 && $past(cnt_q) == CNW'(1))
    else $error("delay ended early"); // RL13
endmodule

// >>> testbench/dsac_integ_model.sv
`timescale 1ns/10ps
module dsac_integ_model
  import dsac_pkg::*;
(
  input  wire dsac_sw_t    int_sw,  // Integrator switches
  input  wire logic        pclk,    // Clock
  input  wire dsac_relay_t relay,   // Divider contacts
  input  wire logic        ac_mode, // AC divider order
  input  wire logic        sign,    // Input sign, 1 positive
  input  wire logic [31:0] mag,     // Reading at full sensitivity
  output logic             cmp_pos  // Integrator output positive
);
  int dn_q;
  int div;

  // AC turns the divider order round
  always_comb begin
    div = 100;
    if (relay.centre) div = 10;
    if (ac_mode ? relay.upper : relay.lower) div = 1;
  end

  always_ff @(posedge pclk) begin
    if (int_sw.reference_discharge_switch) dn_q <= dn_q + 1;
    else dn_q <= 0;
  end

  // Crosses zero once the discharge has run mag/div pulses
  assign cmp_pos = (int_sw.reference_discharge_switch && dn_q >= mag / div)
                   ? !sign : sign;
endmodule

// >>> testbench/test_dual_slope_autorange_control.sv
`timescale 1ns/10ps
module test_dual_slope_autorange_control
  import dsac_pkg::*;
;
  localparam int unsigned SETTLE = 20;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        cmp_pos;
  dsac_sw_t    int_sw;
  dsac_relay_t relay;
  logic        relay_pulse;
  logic        xfer_pulse;
  logic        polarity;
  logic        overload;
  logic [1:0]  dp_pos;
  logic [11:0] display;
  logic [11:0] d_q;
  logic        sign;
  logic        ac;
  logic [31:0] mag;
  logic [31:0] rd;
  logic        err;
  logic [2:0]  dsw;
  int          fail_count;
  int          samples_checked;
  int          rp_cnt;
  int          xp_cnt;
  int          dc_cnt;
  int          rp0;
  int          xp0;
  int          dc0;
  int          up_n;
  int          dn_n;
  int          gap_n;

  dsac_top #(.SETTLE_CYC(SETTLE), .CW(12)) uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .cmp_pos(cmp_pos),
    .int_sw(int_sw), .relay(relay), .relay_pulse(relay_pulse),
    .xfer_pulse(xfer_pulse), .polarity(polarity), .overload(overload),
    .dp_pos(dp_pos), .display(display));

  dsac_integ_model far_end (
    .int_sw(int_sw), .pclk(pclk), .relay(relay), .ac_mode(ac),
    .sign(sign), .mag(mag), .cmp_pos(cmp_pos));

  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  // Event counters sampled by the scenarios
  always @(posedge pclk) begin
    d_q <= display;
    if (relay_pulse === 1'b1) rp_cnt <= rp_cnt + 1;
    if (xfer_pulse === 1'b1) xp_cnt <= xp_cnt + 1;
    if (display !== d_q) dc_cnt <= dc_cnt + 1;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask

  // Counting edge may differ by a pulse or two
  task automatic chk_near(input logic [31:0] got, input int exp);
    samples_checked++;
    if ($isunknown(got) || int'(got) < exp - 2 || int'(got) > exp + 2) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask

  function automatic int div_of(input int r);
    return r == 0 ? 1 : (r == 1 ? 10 : 100);
  endfunction

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q,
                     output logic e);
    int n;
    n = 0;
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      n++;
      @(posedge pclk);
    end
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
    chk(n, 0);
  endtask

  // Runs from the first upward sample to the next one
  task automatic conv();
    rp0 = rp_cnt;
    xp0 = xp_cnt;
    dc0 = dc_cnt;
    up_n = 1;
    dn_n = 0;
    gap_n = 0;
    @(posedge pclk);
    while (int_sw === 3'b011 && up_n < 6000) begin
      up_n++;
      @(posedge pclk);
    end
    dsw = int_sw;
    while (int_sw[2] === 1'b1 && dn_n < 6000) begin
      dn_n++;
      @(posedge pclk);
    end
    while (int_sw !== 3'b011 && gap_n < 6000) begin
      gap_n++;
      @(posedge pclk);
    end
    chk(gap_n < 6000, 1);
  endtask

  task automatic t_reset();
    chk({polarity, overload, dp_pos, display}, 32'h8000);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, 8'h00, 32'h0, rd, err);
    chk(rd, 32'h1);
    apb(1'b0, 8'h10, 32'h0, rd, err);
    chk(err, 1);
    chk(rd, 0);
    @(posedge pclk);
    while (int_sw !== 3'b011) @(posedge pclk);
    conv();
  endtask

  task automatic t_basic();
    conv();
    chk(up_n, 1000);
    chk(xp_cnt - xp0, 1);
    chk(dsw, 3'b101);
    chk_near(display, 500);
    chk(gap_n < 5, 1);
    conv();
    chk(dc_cnt - dc0, 0);
    chk(polarity, 1);
    apb(1'b0, 8'h08, 32'h0, rd, err);
    chk_near(rd, 500);
  endtask

  task automatic t_neg();
    sign <= 1'b0;
    conv();
    chk(polarity, 0);
    chk(dsw, 3'b110);
    chk_near(display, 500);
    sign <= 1'b1;
  endtask

  task automatic t_up();
    mag <= 1500;
    conv();
    chk(rp_cnt - rp0 > 0, 1);
    chk(gap_n >= SETTLE && gap_n < SETTLE + 8, 1);
    chk(dp_pos, 1);
    chk(relay, 3'b010);
    conv();
    chk_near(display, 150);
    chk(gap_n < 5, 1);
    mag <= 150000;
    conv();
    conv();
    chk(overload, 1);
    chk({dp_pos, relay}, 5'h14);
    apb(1'b0, 8'h04, 32'h0, rd, err);
    chk(rd[9:7], 3'b110);
  endtask

  task automatic t_down();
    mag <= 500;
    conv();
    chk(dp_pos, 1);
    conv();
    chk({dp_pos, relay}, 5'h01);
    conv();
    chk(gap_n < 5, 1);
    chk(overload, 0);
    chk_near(display, 500);
    mag <= 50;
    conv();
    chk(gap_n < 5, 1);
    chk(dp_pos, 0);
  endtask

  task automatic t_manual();
    mag <= 500;
    ac <= 1'b1;
    for (int i = 1; i < 4; i++) begin
      apb(1'b1, 8'h00, {28'h0, 2'(i), 2'b11}, rd, err);
      conv();
      conv();
      chk(dp_pos, i - 1);
      chk(relay, 3'b100 >> (i - 1));
      chk_near(display, 500 / div_of(i - 1));
      chk(gap_n < 5, 1);
    end
  endtask

  task automatic give_verdict();
    $display("Checks %0d, mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (90000) @(posedge pclk);
    fail_count++;
    give_verdict();
  end

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    sign = 1'b1;
    ac = 1'b0;
    mag = 500;
    repeat (20) @(posedge pclk);
    t_reset();
    t_basic();
    t_neg();
    t_up();
    t_down();
    t_manual();
    give_verdict();
  end
endmodule
